// ==== bench/gauge_partner.sv ====
`timescale 1ns/10ps
module gauge_partner
#(
    parameter int OCV_DELAY = 6,
    parameter int INHIBIT_LOW = 0,
    parameter int INHIBIT_HIGH = 45,
    parameter int SUSPEND_MARGIN = 10
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic ocv_start_in,
    input wire logic profile_start_in,
    input wire logic battery_good_in,
    input wire logic good_pol_in,
    input wire logic signed [7:0] temp_in,
    output logic ocv_done_out,
    output logic profile_done_out,
    output logic charge_en_out
);
    // suspend window encloses inhibit: both edges are widened by one margin.
    localparam int SUSPEND_LOW = INHIBIT_LOW - SUSPEND_MARGIN;
    localparam int SUSPEND_HIGH = INHIBIT_HIGH + SUSPEND_MARGIN;
    int count;
    logic charge_ok;
    logic charging;
    // charge held off: the charger runs only once battery-good reads active.
    assign charge_ok = battery_good_in ^ good_pol_in;
    assign charge_en_out = charging;
    // A slow reading leaves the gauge waiting several cycles, as a real converter would.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count <= 0;
            charging <= 1'b0;
            ocv_done_out <= 1'b0;
            profile_done_out <= 1'b0;
        end
        else
        begin
            ocv_done_out <= (count == 1);
            profile_done_out <= profile_start_in;
            if (ocv_start_in)
                count <= OCV_DELAY;
            else if (count != 0)
                count <= count - 1;
            if (!charge_ok)
                charging <= 1'b0;
            else if (!charging)
                charging <= (temp_in >= INHIBIT_LOW) && (temp_in <= INHIBIT_HIGH);
            else
                charging <= (temp_in >= SUSPEND_LOW) && (temp_in <= SUSPEND_HIGH);
        end
    end
endmodule : gauge_partner

// ==== bench/gauge_power_status_monitor.sv ====
`timescale 1ns/10ps
module gauge_power_status_monitor
    import gauge_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    input wire logic [DATA_W-1:0] rd_data_out,
    input wire logic battery_present_in,
    input wire logic open_circuit_voltage_done_in,
    input wire logic host_cmd_in,
    input wire logic host_cmd_done_in,
    input wire logic wake_current_in,
    input wire logic comm_wake_in,
    input wire logic pin_wake_in,
    input wire logic battery_good_out,
    input wire logic hf_osc_en_out,
    input wire logic lf_osc_en_out,
    input wire logic cpu_run_out,
    input wire logic ocv_start_out,
    input wire logic profile_start_out,
    input wire logic [7:0] mode_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_ocv_entry: assert property (
        mode_out == ST_INSERT_WAIT && battery_present_in && !host_cmd_in |=> mode_out == ST_OCV_MEASURE)
        else $error("insertion did not start the reading");
    a_ocv_start_pulse: assert property (
        ocv_start_out |-> mode_out == ST_OCV_MEASURE ##1 !ocv_start_out)
        else $error("reading start pulse malformed");
    a_ocv_to_profile: assert property (
        mode_out == ST_OCV_MEASURE && open_circuit_voltage_done_in && battery_present_in
        |=> mode_out == ST_PROFILE_SEL && profile_start_out)
        else $error("profile selection did not follow the reading");
    a_good_on_done: assert property (
        mode_out == ST_OCV_MEASURE && open_circuit_voltage_done_in && battery_present_in
        |=> battery_good_out != $past(battery_good_out))
        else $error("battery good did not switch on completed reading");
    a_good_held_off: assert property (
        mode_out == ST_OCV_MEASURE && !open_circuit_voltage_done_in && !$past(wr_strobe_in)
        |=> $stable(battery_good_out))
        else $error("battery good moved before the reading completed");
    a_lf_osc_run: assert property (
        lf_osc_en_out == (mode_out != ST_HIBERNATE))
        else $error("low frequency oscillator wrong for mode");
    a_sleep_osc: assert property (
        mode_out == ST_SLEEP |-> !hf_osc_en_out && lf_osc_en_out)
        else $error("high frequency oscillator running in sleep");
    a_sleep_plus_osc: assert property (
        mode_out == ST_SLEEP_PLUS |-> hf_osc_en_out && lf_osc_en_out)
        else $error("oscillator stopped in sleep plus");
    a_normal_run: assert property (
        mode_out == ST_NORMAL |-> cpu_run_out && hf_osc_en_out)
        else $error("normal mode not fully powered");
    a_wake_sleep: assert property (
        mode_out == ST_SLEEP && wake_current_in && battery_present_in |=> mode_out == ST_NORMAL)
        else $error("wake current did not end sleep");
    a_hib_wake: assert property (
        mode_out == ST_HIBERNATE && (comm_wake_in || pin_wake_in) && battery_present_in |=> mode_out == ST_NORMAL)
        else $error("wake event did not end hibernate");
    a_cmd_return: assert property (
        mode_out == ST_CMD_SERVICE && host_cmd_done_in |=> mode_out == ST_INSERT_WAIT)
        else $error("command service did not return to waiting");
    a_rd_idle_zero: assert property (
        !$past(rd_strobe_in) |-> rd_data_out == 16'h0000)
        else $error("read data outside its cycle");
endmodule : gauge_power_status_monitor

bind gauge_power_status gauge_power_status_monitor mon (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
    .rd_data_out(rd_data_out), .battery_present_in(battery_present_in),
    .open_circuit_voltage_done_in(open_circuit_voltage_done_in), .host_cmd_in(host_cmd_in),
    .host_cmd_done_in(host_cmd_done_in), .wake_current_in(wake_current_in), .comm_wake_in(comm_wake_in),
    .pin_wake_in(pin_wake_in), .battery_good_out(battery_good_out), .hf_osc_en_out(hf_osc_en_out),
    .lf_osc_en_out(lf_osc_en_out), .cpu_run_out(cpu_run_out), .ocv_start_out(ocv_start_out),
    .profile_start_out(profile_start_out), .mode_out(mode_out)
);

// ==== bench/gauge_power_status_tb.sv ====
`timescale 1ns/10ps
module gauge_power_status_tb
    import gauge_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, bat = 1'b0, gpol = 1'b0;
    logic [15:0] cap = 16'h0100, avg = 16'h0100;
    logic [4:0] ev = 5'h00;
    logic [15:0] rdata;
    logic low_b, good, tsel, gsel, hf, lf, run, meas, ocv_s, prof_s, ocv_d, prof_d, chg;
    logic [7:0] mode;
    int fail_count = 0, compares = 0;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h20};
    logic [15:0] rv [7] = '{16'h000c, 16'h0000, 16'h0096, 16'h000a, 16'h0100, 16'h0100, 16'h0000};
    logic [15:0] cv [5] = '{16'h0097, 16'h0095, 16'h0096, 16'h0097, 16'h0095};
    logic [15:0] lv [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0001};
    logic signed [7:0] temp = 8'sd25;
    logic signed [7:0] tv [4] = '{8'sd50, 8'sd60, 8'sd50, 8'sd25};
    logic [15:0] tc [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0001};

    gauge_power_status #(.NORMAL_MEAS_PERIOD(32'h14), .SLEEP_MEAS_PERIOD(32'h32)) dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr),
        .rd_strobe_in(rd), .rd_data_out(rdata), .compensated_remaining_capacity_in(cap),
        .average_current_value_in(avg), .battery_present_in(bat), .open_circuit_voltage_done_in(ocv_d),
        .profile_done_in(prof_d), .host_cmd_in(ev[0]), .host_cmd_done_in(ev[1]), .wake_current_in(ev[2]),
        .comm_wake_in(ev[3]), .pin_wake_in(ev[4]), .low_battery_out(low_b), .battery_good_out(good),
        .temp_onchip_sel_out(tsel), .adc_ground_sel_out(gsel), .hf_osc_en_out(hf), .lf_osc_en_out(lf),
        .cpu_run_out(run), .measure_req_out(meas), .ocv_start_out(ocv_s), .profile_start_out(prof_s),
        .mode_out(mode));
    gauge_partner far (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ocv_start_in(ocv_s),
        .profile_start_in(prof_s), .battery_good_in(good), .good_pol_in(gpol), .ocv_done_out(ocv_d),
        .temp_in(temp), .profile_done_out(prof_d), .charge_en_out(chg));

    initial
    begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic report_and_stop();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk

    task automatic pulse(input int w);
        @(posedge ref_clk_in);
        ev[w] <= 1'b1;
        @(posedge ref_clk_in);
        ev <= 5'h00;
    endtask : pulse

    // A bound on every wait keeps a stuck mode machine from hanging the run.
    task automatic wait_mode(input logic [7:0] m);
        int i;
        // Read settled values: a one-cycle mode would be missed if read at its launching edge.
        #1;
        for (i = 0; i < 200 && mode !== m; i++)
        begin
            @(posedge ref_clk_in);
            #1;
        end
        chk(16'(mode), 16'(m));
        if (mode !== m)
            report_and_stop();
    endtask : wait_mode

    task automatic wait_meas(input int n);
        int i;
        logic seen;
        seen = 1'b0;
        for (i = 0; i < n; i++)
        begin
            @(posedge ref_clk_in);
            #1;
            seen |= (meas === 1'b1);
        end
        chk(16'(seen), 16'h0001);
    endtask : wait_meas

    initial
    begin
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        #1;
        chk({mode, 3'b000, good, lf, low_b, tsel, gsel}, 16'h0108);
        wr_reg(OFF_CAPACITY, 16'hffff);
        wr_reg(8'h20, 16'hffff);
        for (int k = 0; k < 7; k++)
            rd_chk(ra[k], rv[k]);
        pulse(0);
        wait_mode(ST_CMD_SERVICE);
        chk(16'(run), 16'h0001);
        pulse(1);
        wait_mode(ST_INSERT_WAIT);
        wr_reg(OFF_CONFIG_B, 16'h0001);
        wr_reg(OFF_CONFIG, 16'h0008);
        @(posedge ref_clk_in);
        #1;
        chk(16'({tsel, gsel}), 16'h0003);
        wr_reg(OFF_CONFIG, 16'h000e);
        @(posedge ref_clk_in);
        gpol <= 1'b1;
        #1;
        chk(16'({tsel, good}), 16'h0001);
        @(posedge ref_clk_in);
        bat <= 1'b1;
        wait_mode(ST_OCV_MEASURE);
        chk(16'({good, chg}), 16'h0002);
        wait_mode(ST_NORMAL);
        chk(16'({good, chg}), 16'h0001);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge ref_clk_in);
            temp <= tv[k];
            @(posedge ref_clk_in);
            #1;
            chk(16'(chg), tc[k]);
        end
        rd_chk(OFF_STATUS, 16'h1006);
        wr_reg(OFF_CONFIG, 16'h000c);
        @(posedge ref_clk_in);
        gpol <= 1'b0;
        #1;
        chk(16'(good), 16'h0001);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge ref_clk_in);
            cap <= cv[k];
            repeat (3) @(posedge ref_clk_in);
            #1;
            chk(16'(low_b), lv[k]);
        end
        rd_chk(OFF_STATUS, 16'h1007);
        wr_reg(OFF_CONFIG, 16'h000d);
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk(16'(low_b), 16'h0000);
        wr_reg(OFF_CONFIG, 16'h0004);
        cap <= 16'h0100;
        wait_meas(25);
        @(posedge ref_clk_in);
        avg <= 16'h0005;
        repeat (5) @(posedge ref_clk_in);
        #1;
        chk(16'(mode), 16'(ST_NORMAL));
        wr_reg(OFF_CONFIG, 16'h000c);
        wait_mode(ST_SLEEP);
        chk(16'({hf, lf}), 16'h0001);
        wait_meas(55);
        pulse(2);
        wait_mode(ST_NORMAL);
        wait_mode(ST_SLEEP);
        @(posedge ref_clk_in);
        avg <= 16'h0100;
        wait_mode(ST_NORMAL);
        wr_reg(OFF_CONFIG, 16'h001c);
        avg <= 16'h0005;
        wait_mode(ST_SLEEP_PLUS);
        chk(16'({hf, lf}), 16'h0003);
        @(posedge ref_clk_in);
        avg <= 16'h0100;
        wait_mode(ST_NORMAL);
        for (int w = 3; w < 5; w++)
        begin
            wr_reg(OFF_CONTROL, 16'h0001);
            wait_mode(ST_HIBERNATE);
            chk(16'({hf, lf}), 16'h0000);
            pulse(w);
            wait_mode(ST_NORMAL);
        end
        @(posedge ref_clk_in);
        bat <= 1'b0;
        wait_mode(ST_INSERT_WAIT);
        chk(16'(good), 16'h0000);
        report_and_stop();
    end
endmodule : gauge_power_status_tb

// ==== logic/capacity_flag.sv ====
`timescale 1ns/10ps
module capacity_flag
    import gauge_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [CAP_W-1:0] capacity_in,
    input wire logic [CAP_W-1:0] threshold_in,
    output logic flag_out
);
    logic next_flag;

    // Equal to the threshold keeps the old state, which gives one count of hysteresis.
    always_comb
    begin
        next_flag = flag_out;
        if (capacity_in < threshold_in)
            next_flag = 1'b1;
        else if (capacity_in > threshold_in)
            next_flag = 1'b0;
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            flag_out <= 1'b0;
        else
            flag_out <= next_flag;
    end
endmodule : capacity_flag

// ==== logic/gauge_pkg.sv ====
package gauge_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CAP_W = 16;

    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_CONFIG_B = 8'h04;
    localparam logic [7:0] OFF_LOW_THRESH = 8'h08;
    localparam logic [7:0] OFF_SLEEP_THRESH = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_CAPACITY = 8'h18;

    localparam int CFG_LOW_POL = 0;
    localparam int CFG_GOOD_POL = 1;
    localparam int CFG_TEMP_SRC = 2;
    localparam int CFG_SLEEP_EN = 3;
    localparam int CFG_SLEEP_PLUS_EN = 4;
    localparam int CFGB_GND_SEL = 0;
    localparam int CTRL_HIBERNATE = 0;
    localparam int STAT_LOW_CHARGE = 0;
    localparam int STAT_OCV_GOOD = 1;
    localparam int STAT_BAT_DET = 2;
    localparam int STAT_MODE_LSB = 8;

    localparam logic [4:0] CONFIG_RESET = 5'h0c;
    localparam logic CONFIG_B_RESET = 1'b0;
    localparam logic [15:0] LOW_THRESH_RESET = 16'h0096;
    localparam logic [15:0] SLEEP_THRESH_RESET = 16'h000a;

    localparam longint CLK_PERIOD_NS = 10;
    localparam longint NORMAL_MEAS_PERIOD_MS = 1000;
    localparam longint SLEEP_MEAS_PERIOD_MS = 20000;
    localparam longint NORMAL_MEAS_CYCLES = NORMAL_MEAS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam longint SLEEP_MEAS_CYCLES = SLEEP_MEAS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [7:0] {
        ST_INSERT_WAIT = 8'h01,
        ST_CMD_SERVICE = 8'h02,
        ST_OCV_MEASURE = 8'h04,
        ST_PROFILE_SEL = 8'h08,
        ST_NORMAL = 8'h10,
        ST_SLEEP = 8'h20,
        ST_SLEEP_PLUS = 8'h40,
        ST_HIBERNATE = 8'h80
    } power_mode_t;
endpackage : gauge_pkg

// ==== logic/gauge_power_status.sv ====
// Contract
// - Set low-charge flag when compensated remaining capacity falls below threshold.
// - Clear low-charge flag once remaining capacity rises above threshold.
// - Low-battery pin continuously follows the low-charge flag.
// - Low-battery polarity bit inverts the low-battery pin level.
// - After insertion, battery-good stays negated until open-circuit reading is valid.
// - Assert battery-good as soon as the open-circuit reading completes.
// - Battery-good polarity bit selects the battery-good active level.
// - Thermistor input is the default; on-chip sensor only when select bit clear.
// - Ground-select bit picks converter ground for temperature measurement.
// - Five power modes; normal mode fully powered and runs any task.
// - Sleep-plus keeps both low and high frequency oscillators running.
// - Sleep stops high frequency oscillator yet still measures periodically.
// - Hibernate is very low power, woken by communication or pin activity.
// - No battery: halt in insertion wait; on insertion measure, assert good, select profile.
// - In insertion wait, wake for a host command then return halted.
// - Normal is the default; measures, refreshes data and decides mode changes.
// - Enter sleep only with sleep enable set and average current below threshold.
// - Leave sleep when current exceeds threshold or wake current is sensed.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module gauge_power_status
    import gauge_pkg::*;
#(
    parameter logic [31:0] NORMAL_MEAS_PERIOD = 32'(NORMAL_MEAS_CYCLES),
    parameter logic [31:0] SLEEP_MEAS_PERIOD = 32'(SLEEP_MEAS_CYCLES)
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [DATA_W-1:0] rd_data_out,
    input wire logic [CAP_W-1:0] compensated_remaining_capacity_in,
    input wire logic signed [CAP_W-1:0] average_current_value_in,
    input wire logic battery_present_in,
    input wire logic open_circuit_voltage_done_in,
    input wire logic profile_done_in,
    input wire logic host_cmd_in,
    input wire logic host_cmd_done_in,
    input wire logic wake_current_in,
    input wire logic comm_wake_in,
    input wire logic pin_wake_in,
    output logic low_battery_out,
    output logic battery_good_out,
    output logic temp_onchip_sel_out,
    output logic adc_ground_sel_out,
    output logic hf_osc_en_out,
    output logic lf_osc_en_out,
    output logic cpu_run_out,
    output logic measure_req_out,
    output logic ocv_start_out,
    output logic profile_start_out,
    output logic [7:0] mode_out
);
    logic [4:0] config_bits;
    logic gnd_select;
    logic [CAP_W-1:0] low_charge_threshold;
    logic [CAP_W-1:0] sleep_threshold;
    logic hibernate_req;
    logic [4:0] next_config_bits;
    logic next_gnd_select;
    logic [CAP_W-1:0] next_low_charge_threshold;
    logic [CAP_W-1:0] next_sleep_threshold;
    logic next_hibernate_req;
    logic [DATA_W-1:0] next_rd_data;

    power_mode_t mode;
    power_mode_t next_mode;
    logic ocv_good;
    logic next_ocv_good;
    logic low_charge_flag;
    logic meas_tick;
    logic timer_restart;
    logic [31:0] meas_period;
    logic sleep_qualified;
    logic next_low_battery;
    logic next_battery_good;
    logic next_temp_onchip;
    logic next_adc_ground;
    logic next_hf_osc;
    logic next_lf_osc;
    logic next_cpu_run;
    logic next_measure_req;
    logic next_ocv_start;
    logic next_profile_start;

    capacity_flag u_low_charge
    (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .capacity_in(compensated_remaining_capacity_in),
        .threshold_in(low_charge_threshold),
        .flag_out(low_charge_flag)
    );

    period_timer u_meas_timer
    (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .restart_in(timer_restart),
        .period_in(meas_period),
        .tick_out(meas_tick)
    );

    // Register file. A read answers in the next cycle; unmapped reads return zero.
    always_comb
    begin
        next_config_bits = config_bits;
        next_gnd_select = gnd_select;
        next_low_charge_threshold = low_charge_threshold;
        next_sleep_threshold = sleep_threshold;
        next_hibernate_req = hibernate_req;
        next_rd_data = '0;
        if (wr_strobe_in)
        begin
            case (addr_in)
                OFF_CONFIG: next_config_bits = wr_data_in[4:0];
                OFF_CONFIG_B: next_gnd_select = wr_data_in[CFGB_GND_SEL];
                OFF_LOW_THRESH: next_low_charge_threshold = wr_data_in;
                OFF_SLEEP_THRESH: next_sleep_threshold = wr_data_in;
                OFF_CONTROL: next_hibernate_req = wr_data_in[CTRL_HIBERNATE];
                default: next_hibernate_req = hibernate_req;
            endcase
        end
        // The request is consumed by entry into hibernate, so one write gives one entry.
        if (mode == ST_HIBERNATE)
            next_hibernate_req = 1'b0;
        if (rd_strobe_in)
        begin
            case (addr_in)
                OFF_CONFIG: next_rd_data = {11'h0, config_bits};
                OFF_CONFIG_B: next_rd_data = {15'h0, gnd_select};
                OFF_LOW_THRESH: next_rd_data = low_charge_threshold;
                OFF_SLEEP_THRESH: next_rd_data = sleep_threshold;
                OFF_CONTROL: next_rd_data = {15'h0, hibernate_req};
                OFF_STATUS: next_rd_data = {mode, 5'h0, battery_present_in, ocv_good, low_charge_flag};
                OFF_CAPACITY: next_rd_data = compensated_remaining_capacity_in;
                default: next_rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            config_bits <= CONFIG_RESET;
            gnd_select <= CONFIG_B_RESET;
            low_charge_threshold <= LOW_THRESH_RESET;
            sleep_threshold <= SLEEP_THRESH_RESET;
            hibernate_req <= 1'b0;
            rd_data_out <= '0;
        end
        else
        begin
            config_bits <= next_config_bits;
            gnd_select <= next_gnd_select;
            low_charge_threshold <= next_low_charge_threshold;
            sleep_threshold <= next_sleep_threshold;
            hibernate_req <= next_hibernate_req;
            rd_data_out <= next_rd_data;
        end
    end

    assign sleep_qualified = config_bits[CFG_SLEEP_EN]
        && (average_current_value_in < $signed(sleep_threshold));

    // Power mode sequencing.
    always_comb
    begin
        next_mode = mode;
        next_ocv_good = ocv_good;
        case (mode)
            ST_INSERT_WAIT:
            begin
                if (battery_present_in)
                    next_mode = ST_OCV_MEASURE;
                else if (host_cmd_in)
                    next_mode = ST_CMD_SERVICE;
            end
            ST_CMD_SERVICE:
            begin
                if (host_cmd_done_in)
                    next_mode = ST_INSERT_WAIT;
            end
            ST_OCV_MEASURE:
            begin
                if (open_circuit_voltage_done_in)
                begin
                    next_ocv_good = 1'b1;
                    next_mode = ST_PROFILE_SEL;
                end
            end
            ST_PROFILE_SEL:
            begin
                if (profile_done_in)
                    next_mode = ST_NORMAL;
            end
            ST_NORMAL:
            begin
                if (hibernate_req)
                    next_mode = ST_HIBERNATE;
                else if (sleep_qualified)
                    next_mode = config_bits[CFG_SLEEP_PLUS_EN] ? ST_SLEEP_PLUS : ST_SLEEP;
            end
            ST_SLEEP, ST_SLEEP_PLUS:
            begin
                if (average_current_value_in > $signed(sleep_threshold) || wake_current_in)
                    next_mode = ST_NORMAL;
            end
            ST_HIBERNATE:
            begin
                if (comm_wake_in || pin_wake_in)
                    next_mode = ST_NORMAL;
            end
            default: next_mode = ST_INSERT_WAIT;
        endcase
        if (!battery_present_in && mode != ST_INSERT_WAIT && mode != ST_CMD_SERVICE)
        begin
            next_mode = ST_INSERT_WAIT;
            next_ocv_good = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            mode <= ST_INSERT_WAIT;
            ocv_good <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            ocv_good <= next_ocv_good;
        end
    end

    // The timer restarts on every mode change so the first sample follows a full period.
    assign timer_restart = (next_mode != mode);
    assign meas_period = (mode == ST_NORMAL) ? NORMAL_MEAS_PERIOD : SLEEP_MEAS_PERIOD;

    // Pin and control outputs, all registered; mode, oscillator, run and good outputs from next-state values.
    always_comb
    begin
        next_low_battery = low_charge_flag ^ config_bits[CFG_LOW_POL];
        next_battery_good = next_ocv_good ^ config_bits[CFG_GOOD_POL];
        next_temp_onchip = !config_bits[CFG_TEMP_SRC];
        next_adc_ground = gnd_select;
        next_cpu_run = (next_mode == ST_NORMAL) || (next_mode == ST_CMD_SERVICE)
            || (next_mode == ST_OCV_MEASURE) || (next_mode == ST_PROFILE_SEL);
        next_hf_osc = next_cpu_run || (next_mode == ST_SLEEP_PLUS);
        next_lf_osc = (next_mode != ST_HIBERNATE);
        next_measure_req = meas_tick && !timer_restart
            && (mode == ST_NORMAL || mode == ST_SLEEP || mode == ST_SLEEP_PLUS);
        next_ocv_start = (next_mode == ST_OCV_MEASURE) && (mode != ST_OCV_MEASURE);
        next_profile_start = (next_mode == ST_PROFILE_SEL) && (mode != ST_PROFILE_SEL);
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            low_battery_out <= 1'b0;
            battery_good_out <= 1'b0;
            temp_onchip_sel_out <= 1'b0;
            adc_ground_sel_out <= 1'b0;
            hf_osc_en_out <= 1'b0;
            lf_osc_en_out <= 1'b1;
            cpu_run_out <= 1'b0;
            measure_req_out <= 1'b0;
            ocv_start_out <= 1'b0;
            profile_start_out <= 1'b0;
            mode_out <= ST_INSERT_WAIT;
        end
        else
        begin
            low_battery_out <= next_low_battery;
            battery_good_out <= next_battery_good;
            temp_onchip_sel_out <= next_temp_onchip;
            adc_ground_sel_out <= next_adc_ground;
            hf_osc_en_out <= next_hf_osc;
            lf_osc_en_out <= next_lf_osc;
            cpu_run_out <= next_cpu_run;
            measure_req_out <= next_measure_req;
            ocv_start_out <= next_ocv_start;
            profile_start_out <= next_profile_start;
            mode_out <= next_mode;
        end
    end
endmodule : gauge_power_status

// ==== logic/period_timer.sv ====
`timescale 1ns/10ps
module period_timer
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic restart_in,
    input wire logic [31:0] period_in,
    output logic tick_out
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_tick;

    always_comb
    begin
        next_count = count + 32'h1;
        next_tick = 1'b0;
        if (restart_in)
            next_count = 32'h0;
        else if (count >= period_in - 32'h1)
        begin
            next_count = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count <= 32'h0;
            tick_out <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick_out <= next_tick;
        end
    end
endmodule : period_timer
